// ### wdrc_defines.svh
// Constants for the watchdog and reset control block.
// Assumes it is included by the package and the design modules only.
// How it works
// - Overflow while running gives full reset
// - Disabled watchdog ignores its clear instructions
// - Runs if option set or key enables
// - Key 1010B with option off disables
// - Other key values enable; 0101B preferred
// - Clock source picked by build option
// - System-clock source stops during sleep
// - Period code selects 2^8 to 2^15
// - All period bits set gives longest
// - Running time-out resets and sets flag
// - Sleep time-out wakes, resets PC/SP only
// - Pin, clear instruction or sleep clears
// - Option picks single or paired clearing
// - Paired clears must alternate to count
// - Every reset forces program counter zero
// - Pin low resets; resume after release
// - Extra 100ms delay after pin release
// - Power-on sets port registers all ones
// - Low-voltage reset equals pin reset
// - Period register bits 7~3 read zero
// - Powerdown flag: sleep sets, clear clears
// - Sleep clears counter, independent clock continues
`ifndef WDRC_DEFINES_SVH
`define WDRC_DEFINES_SVH
`define WDRC_PERIOD_RESET 3'h7
`define WDRC_KEY_RESET 4'hA
`define WDRC_KEY_OFF 4'hA
`define WDRC_KEY_RECOMMENDED 4'h5
`define WDRC_PERIOD_BASE_EXP 8
`define WDRC_CNT_W 16
`define WDRC_RSTD_MS 100
`define WDRC_CLK_MHZ 100
`define WDRC_RSTD_CYCLES (`WDRC_RSTD_MS * 1000 * `WDRC_CLK_MHZ)
`define WDRC_SYSDIV 4
`define WDRC_PORT_RESET 8'hFF
`define WDRC_SRC_LXT 2'h0
`define WDRC_SRC_SYSDIV 2'h1
`define WDRC_SRC_LOW_SPEED_INTERNAL_OSC 2'h2
`endif

// ### wdrc_pkg.sv
// Types shared by the watchdog and reset control block.
// Assumes wdrc_defines.svh is alongside.
`default_nettype none
`include "wdrc_defines.svh"
package wdrc_pkg;
  // Software instructions aimed at the watchdog
  typedef struct packed {
    logic single_clear_instr;
    logic first_paired_clear_instr;
    logic second_paired_clear_instr;
    logic sleep_instr;
  } wdrc_instr_t;
  // Build-time options
  typedef struct packed {
    logic guard_enable_opt;
    logic paired_clear_opt;
    logic [1:0] clk_source;
  } wdrc_opt_t;
  // Reset sequencer states
  typedef enum logic [1:0] {WDRC_RUN, WDRC_HOLD, WDRC_DELAY} wdrc_rst_state_t;
endpackage : wdrc_pkg
`default_nettype wire

// ### wdrc_tick.sv
// Selects the watchdog count tick from the three clock sources.
// Assumes source tick inputs are one-cycle pulses synchronous to ref_clk.
`default_nettype none
`include "wdrc_defines.svh"
module wdrc_tick
  import wdrc_pkg::*;
(
  // Clock and control
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Sources and options
  input wire logic [1:0] clk_source,
  input wire logic low_freq_crystal_tick,
  input wire logic low_speed_internal_osc_tick,
  input wire logic sleeping,
  // Selected tick
  output logic wdt_tick
);
  logic [1:0] sys_div;
  logic sys_tick;
  // ****************************************
  // System clock divided by four
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sys_div <= 2'h0;
    end else if (clk_en && !sleeping) begin
      sys_div <= sys_div + 2'h1;
    end
  end
  // Instruction clock stops in sleep
  assign sys_tick = !sleeping && (sys_div == 2'(`WDRC_SYSDIV - 1));
  // Source selection
  assign wdt_tick = (clk_source == `WDRC_SRC_LXT) ? low_freq_crystal_tick :
                    (clk_source == `WDRC_SRC_SYSDIV) ? sys_tick :
                    (clk_source == `WDRC_SRC_LOW_SPEED_INTERNAL_OSC) ? low_speed_internal_osc_tick : 1'b0;
endmodule : wdrc_tick
`default_nettype wire

// ### wdrc_clear.sv
// Decodes the watchdog clear instructions into one clear pulse.
// Assumes instruction strobes are one-cycle pulses.
`default_nettype none
`include "wdrc_defines.svh"
module wdrc_clear
  import wdrc_pkg::*;
(
  // Clock and control
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Instructions
  input wire wdrc_instr_t instr,
  input wire logic paired_clear_opt,
  input wire logic wdt_on,
  // Result
  output logic sw_clear
);
  logic last_was_first;
  logic last_was_second;
  logic first_ok;
  logic second_ok;
  // Paired clears must alternate
  assign first_ok = wdt_on && instr.first_paired_clear_instr && !last_was_first;
  assign second_ok = wdt_on && instr.second_paired_clear_instr && !last_was_second;
  // Mode chosen by option; off means no effect
  assign sw_clear = paired_clear_opt ? (first_ok || second_ok) :
                    (wdt_on && instr.single_clear_instr);
  // ****************************************
  // Remember last paired clear
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      last_was_first <= 1'b0;
      last_was_second <= 1'b0;
    end else if (clk_en && paired_clear_opt) begin
      if (first_ok) begin
        last_was_first <= 1'b1;
        last_was_second <= 1'b0;
      end else if (second_ok) begin
        last_was_first <= 1'b0;
        last_was_second <= 1'b1;
      end
    end
  end
endmodule : wdrc_clear
`default_nettype wire

// ### wdrc_top.sv
// Watchdog counter, reset sequencer, status flags and guard registers.
// Assumes a simple synchronous data-memory register port and one-cycle
// instruction strobes from the core.
`default_nettype none
`include "wdrc_defines.svh"
module wdrc_top
  import wdrc_pkg::*;
#(
  parameter int RSTD_CYCLES = `WDRC_RSTD_CYCLES
) (
  // Clock and control
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Reset sources
  input wire logic external_reset_pin_n,
  input wire logic low_voltage_reset,
  // Build options and clock ticks
  input wire wdrc_opt_t opt,
  input wire logic low_freq_crystal_tick,
  input wire logic low_speed_internal_osc_tick,
  // Core instructions
  input wire wdrc_instr_t instr,
  // Register port
  input wire logic period_wr,
  input wire logic key_wr,
  input wire logic [7:0] wr_data,
  // Register read-back
  output logic [7:0] guard_period_register,
  output logic [3:0] guard_enable_key,
  // Status
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic sleeping,
  output logic wdt_on,
  // Resets to the core
  output logic core_reset,
  output logic pc_sp_reset,
  output logic [7:0] port_data_init,
  output logic [7:0] port_dir_init
);
  logic [2:0] period_sel;
  logic [3:0] key;
  logic [`WDRC_CNT_W-1:0] wdt_cnt;
  logic [`WDRC_CNT_W-1:0] period_limit;
  logic wdt_tick;
  logic sw_clear;
  logic wdt_overflow;
  logic next_wdt_on;
  logic pin_reset;
  logic hold_reset;
  logic counter_clear;
  logic [31:0] delay_cnt;
  logic delay_done;
  logic por_done;
  wdrc_rst_state_t rst_state;

  // ****************************************
  // Enable decode
  // ****************************************
  // Option or key turns on; off only for 1010B
  assign next_wdt_on = opt.guard_enable_opt || (key != `WDRC_KEY_OFF);

  // ****************************************
  // Sub-blocks
  // ****************************************
  wdrc_tick u_tick (
    .ref_clk(ref_clk),
    .srst(srst),
    .clk_en(clk_en),
    .clk_source(opt.clk_source),
    .low_freq_crystal_tick(low_freq_crystal_tick),
    .low_speed_internal_osc_tick(low_speed_internal_osc_tick),
    .sleeping(sleeping),
    .wdt_tick(wdt_tick)
  );

  wdrc_clear u_clear (
    .ref_clk(ref_clk),
    .srst(srst),
    .clk_en(clk_en),
    .instr(instr),
    .paired_clear_opt(opt.paired_clear_opt),
    .wdt_on(next_wdt_on),
    .sw_clear(sw_clear)
  );

  // ****************************************
  // Counter decode
  // ****************************************
  // Limit is 2^(8+code) ticks
  assign period_limit = `WDRC_CNT_W'(
    (32'h1 << (`WDRC_PERIOD_BASE_EXP + period_sel)) - 32'h1);
  assign pin_reset = !external_reset_pin_n || low_voltage_reset;
  assign hold_reset = rst_state != WDRC_RUN;
  // Pin, clear instruction or sleep entry clears
  assign counter_clear = pin_reset || sw_clear || instr.sleep_instr || hold_reset;
  assign wdt_overflow = next_wdt_on && wdt_tick && (wdt_cnt == period_limit);
  assign delay_done = delay_cnt >= 32'(RSTD_CYCLES - 1);

  // ****************************************
  // Watchdog counter
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wdt_cnt <= '0;
    end else if (clk_en) begin
      if (counter_clear || wdt_overflow || !next_wdt_on) begin
        wdt_cnt <= '0;
      end else if (wdt_tick) begin
        wdt_cnt <= wdt_cnt + `WDRC_CNT_W'(1);
      end
    end
  end

  // ****************************************
  // Guard registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      period_sel <= `WDRC_PERIOD_RESET;
      key <= `WDRC_KEY_RESET;
    end else if (clk_en) begin
      if (pin_reset || (wdt_overflow && !sleeping)) begin
        period_sel <= `WDRC_PERIOD_RESET;
        key <= `WDRC_KEY_RESET;
      end else begin
        if (period_wr) begin
          period_sel <= wr_data[2:0];
        end
        if (key_wr) begin
          key <= wr_data[3:0];
        end
      end
    end
  end

  // ****************************************
  // Reset sequencer
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rst_state <= WDRC_DELAY;
      delay_cnt <= '0;
    end else if (clk_en) begin
      unique case (rst_state)
        WDRC_RUN: begin
          // Pin/LOW_VOLTAGE_RESET or running overflow cause full reset
          if (pin_reset) begin
            rst_state <= WDRC_HOLD;
          end else if (wdt_overflow && !sleeping) begin
            rst_state <= WDRC_DELAY;
            delay_cnt <= '0;
          end
        end
        WDRC_HOLD: begin
          if (!pin_reset) begin
            rst_state <= WDRC_DELAY;
            delay_cnt <= '0;
          end
        end
        WDRC_DELAY: begin
          // Extra delay after release
          if (pin_reset) begin
            rst_state <= WDRC_HOLD;
          end else if (delay_done) begin
            rst_state <= WDRC_RUN;
          end else begin
            delay_cnt <= delay_cnt + 32'h1;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Flags and sleep state
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      timeout_flag <= 1'b0;
      powerdown_flag <= 1'b0;
      sleeping <= 1'b0;
      por_done <= 1'b0;
    end else if (clk_en) begin
      if (rst_state == WDRC_RUN) begin
        por_done <= 1'b1;
      end
      if (wdt_overflow) begin
        timeout_flag <= 1'b1;
        sleeping <= 1'b0;
      end else if (instr.sleep_instr && !hold_reset) begin
        sleeping <= 1'b1;
        powerdown_flag <= 1'b1;
        timeout_flag <= 1'b0;
      end else if (sw_clear) begin
        powerdown_flag <= 1'b0;
      end
      if (pin_reset) begin
        sleeping <= 1'b0;
      end
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      core_reset <= 1'b1;
      pc_sp_reset <= 1'b1;
      wdt_on <= 1'b0;
      port_data_init <= `WDRC_PORT_RESET;
      port_dir_init <= `WDRC_PORT_RESET;
      guard_period_register <= {5'h00, `WDRC_PERIOD_RESET};
      guard_enable_key <= `WDRC_KEY_RESET;
    end else if (clk_en) begin
      // Any reset zeroes PC; sleep time-out only PC/SP
      core_reset <= hold_reset || pin_reset || (wdt_overflow && !sleeping);
      pc_sp_reset <= hold_reset || pin_reset || wdt_overflow;
      wdt_on <= next_wdt_on;
      port_data_init <= `WDRC_PORT_RESET;
      port_dir_init <= `WDRC_PORT_RESET;
      guard_period_register <= {5'h00, period_sel};
      guard_enable_key <= key;
    end
  end
endmodule : wdrc_top
`default_nettype wire

// ### wdrc_top_assertions.sv
// Concurrent checks on the ports of the watchdog and reset control block.
// Assumes one clock domain and the sync reset srst; bound to wdrc_top below.
`default_nettype none
module wdrc_top_assertions
  import wdrc_pkg::*;
(
  // Clock and control
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Inputs watched
  input wire logic external_reset_pin_n,
  input wire logic low_voltage_reset,
  input wire wdrc_opt_t opt,
  input wire wdrc_instr_t instr,
  input wire logic low_freq_crystal_tick,
  input wire logic low_speed_internal_osc_tick,
  // Outputs watched
  input wire logic [7:0] guard_period_register,
  input wire logic [3:0] guard_enable_key,
  input wire logic timeout_flag,
  input wire logic powerdown_flag,
  input wire logic sleeping,
  input wire logic wdt_on,
  input wire logic core_reset,
  input wire logic pc_sp_reset,
  input wire logic [7:0] port_data_init,
  input wire logic [7:0] port_dir_init
);
  // ********************
  // Port checks
  // ********************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_port_init_ones: assert property (
    port_data_init == 8'hFF && port_dir_init == 8'hFF) else $error("port init not all ones");
  a_period_top_zero: assert property (
    guard_period_register[7:3] == 5'h00) else $error("period upper bits not zero");
  a_key_turns_off: assert property (
    !opt.guard_enable_opt && guard_enable_key == 4'hA && $past(guard_enable_key) == 4'hA
    |-> !wdt_on) else $error("watchdog on with disable key");
  a_key_turns_on: assert property (
    guard_enable_key != 4'hA && $past(guard_enable_key) != 4'hA |-> wdt_on)
    else $error("watchdog off with enable key");
  a_run_timeout_reset: assert property (
    $rose(timeout_flag) && !$past(sleeping) |-> core_reset) else $error("no reset on time-out");
  a_sleep_wake_only: assert property (
    $rose(timeout_flag) && $past(sleeping) |-> pc_sp_reset && !core_reset)
    else $error("sleep time-out reset wrong");
  a_sleep_sets_pd: assert property (
    instr.sleep_instr && clk_en && !core_reset && external_reset_pin_n && !low_voltage_reset
    && !low_freq_crystal_tick && !low_speed_internal_osc_tick && opt.clk_source != 2'h1
    |=> powerdown_flag) else $error("powerdown flag not set by sleep");
  a_pin_lvr_reset: assert property (
    (!external_reset_pin_n || low_voltage_reset) && clk_en |=> core_reset && pc_sp_reset)
    else $error("pin or low-voltage reset missing");
endmodule : wdrc_top_assertions
bind wdrc_top wdrc_top_assertions u_wdrc_top_assertions (.ref_clk, .srst, .clk_en,
  .external_reset_pin_n, .low_voltage_reset, .opt, .instr, .low_freq_crystal_tick,
  .low_speed_internal_osc_tick, .guard_period_register, .guard_enable_key, .timeout_flag,
  .powerdown_flag, .sleeping, .wdt_on, .core_reset, .pc_sp_reset, .port_data_init,
  .port_dir_init);
`default_nettype wire

// ### tb_top.sv
// Self-checking testbench for the watchdog and reset control block.
// Assumes wdrc_top and its bound checker; inputs change on the falling edge.
`default_nettype none
module tb_top
  import wdrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // Signals and design
  // ********************
  logic ref_clk, srst, clk_en, external_reset_pin_n, low_voltage_reset;
  logic low_freq_crystal_tick, low_speed_internal_osc_tick, period_wr, key_wr;
  logic timeout_flag, powerdown_flag, sleeping, wdt_on, core_reset, pc_sp_reset;
  logic [7:0] wr_data, guard_period_register, port_data_init, port_dir_init;
  logic [3:0] guard_enable_key;
  wdrc_opt_t opt;
  wdrc_instr_t instr;
  int mismatches, checks;
  wdrc_top #(.RSTD_CYCLES(20)) u_wdrc_top (.ref_clk, .srst, .clk_en, .external_reset_pin_n,
    .low_voltage_reset, .opt, .low_freq_crystal_tick, .low_speed_internal_osc_tick, .instr,
    .period_wr, .key_wr, .wr_data, .guard_period_register, .guard_enable_key, .timeout_flag,
    .powerdown_flag, .sleeping, .wdt_on, .core_reset, .pc_sp_reset, .port_data_init,
    .port_dir_init);
  // Clock at 100 MHz
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ********************
  // Helper tasks
  // ********************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  // Watchdog clock pulses; returns just after the edge taking the last one
  task automatic tick(input int n);
    repeat (n) begin
      cyc(1);
      low_freq_crystal_tick = 1'b1;
      cyc(1);
      low_freq_crystal_tick = 1'b0;
    end
  endtask : tick
  // Internal oscillator pulses, same timing as tick
  task automatic osc_tick(input int n);
    repeat (n) begin
      cyc(1);
      low_speed_internal_osc_tick = 1'b1;
      cyc(1);
      low_speed_internal_osc_tick = 1'b0;
    end
  endtask : osc_tick
  task automatic wr(input logic key, input logic [7:0] d);
    wr_data = d;
    key_wr = key;
    period_wr = !key;
    cyc(1);
    key_wr = 1'b0;
    period_wr = 1'b0;
    cyc(1);
  endtask : wr
  task automatic ins(input logic [3:0] v);
    instr = wdrc_instr_t'(v);
    cyc(1);
    instr = '0;
    cyc(1);
  endtask : ins
  // Bounded wait for the reset sequencer to let the core run
  task automatic wait_run;
    for (int i = 0; i < 100 && core_reset !== 1'b0; i++) cyc(1);
    chk(core_reset, 1'b0);
  endtask : wait_run
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  // Hang guard
  initial begin
    #200us;
    mismatches++;
    test_done();
  end
  // ********************
  // Test sequence
  // ********************
  initial begin
    {srst, clk_en, external_reset_pin_n, low_voltage_reset} = 4'b1110;
    {low_freq_crystal_tick, low_speed_internal_osc_tick, period_wr, key_wr} = 4'h0;
    wr_data = 8'h00;
    instr = '0;
    opt = '{guard_enable_opt: 1'b0, paired_clear_opt: 1'b0, clk_source: 2'h0};
    cyc(5);
    chk(guard_period_register, 8'h07);
    chk(guard_enable_key, 4'hA);
    chk(port_data_init, 8'hFF);
    chk(port_dir_init, 8'hFF);
    srst = 1'b0;
    cyc(15);
    chk(core_reset, 1'b1);
    wait_run();
    tick(300);
    chk(timeout_flag, 1'b0);
    wr(1'b0, 8'hF8);
    chk(guard_period_register, 8'h00);
    wr(1'b1, 8'h05);
    chk({guard_enable_key, 3'h0, wdt_on}, 8'h51);
    tick(255);
    chk(core_reset, 1'b0);
    tick(1);
    chk({timeout_flag, core_reset}, 8'h03);
    wait_run();
    chk({guard_enable_key, guard_period_register[3:0]}, 8'hA7);
    external_reset_pin_n = 1'b0;
    opt.paired_clear_opt = 1'b1;
    cyc(3);
    chk(core_reset, 1'b1);
    external_reset_pin_n = 1'b1;
    cyc(15);
    chk(core_reset, 1'b1);
    wait_run();
    wr(1'b1, 8'h05);
    wr(1'b0, 8'h00);
    tick(200);
    ins(4'h4);
    tick(200);
    ins(4'h4);
    tick(55);
    chk(core_reset, 1'b0);
    tick(1);
    chk(core_reset, 1'b1);
    wait_run();
    wr(1'b1, 8'h05);
    wr(1'b0, 8'h00);
    tick(100);
    ins(4'h1);
    chk({powerdown_flag, sleeping, timeout_flag}, 8'h06);
    tick(255);
    chk(timeout_flag, 1'b0);
    tick(1);
    chk({timeout_flag, pc_sp_reset, core_reset}, 8'h06);
    chk(guard_enable_key, 4'h5);
    ins(4'h2);
    chk(powerdown_flag, 1'b0);
    wr(1'b1, 8'h0A);
    chk(wdt_on, 1'b0);
    ins(4'h1);
    ins(4'h4);
    chk({powerdown_flag, sleeping}, 8'h03);
    low_voltage_reset = 1'b1;
    cyc(2);
    chk(core_reset, 1'b1);
    low_voltage_reset = 1'b0;
    wait_run();
    chk(guard_period_register, 8'h07);
    // Divided system clock: sleep at period code 7, single clear, option enable
    opt = '{guard_enable_opt: 1'b1, paired_clear_opt: 1'b0, clk_source: 2'h1};
    ins(4'h1);
    cyc(1100);
    chk({sleeping, timeout_flag}, 8'h02);
    external_reset_pin_n = 1'b0;
    cyc(2);
    external_reset_pin_n = 1'b1;
    wait_run();
    chk(wdt_on, 1'b1);
    wr(1'b0, 8'h00);
    cyc(500);
    ins(4'h8);
    cyc(1010);
    chk({timeout_flag, core_reset}, 8'h00);
    cyc(15);
    chk({timeout_flag, core_reset}, 8'h03);
    wait_run();
    // Internal oscillator keeps counting in sleep
    wr(1'b1, 8'h05);
    opt = '{guard_enable_opt: 1'b0, paired_clear_opt: 1'b0, clk_source: 2'h2};
    wr(1'b0, 8'h00);
    ins(4'h1);
    tick(300);
    chk(timeout_flag, 1'b0);
    osc_tick(256);
    chk({timeout_flag, pc_sp_reset, core_reset}, 8'h06);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
